// file: sink_pkg.sv
// package: constants for the serial-in latched sink driver
// assumes: shared by the top module and the chain module
package sink_pkg;
    // ==========================================================
    // widths
    localparam int CHAN_COUNT = 12;                 // sink channels and stage count
    // ==========================================================
    // reset values
    localparam logic [11:0] CHAIN_RST = 12'h000;    // shift stages after clear
    localparam logic [11:0] LATCH_RST = 12'h000;    // storage latch after clear
    localparam logic        BIT_RST   = 1'h0;       // single-bit flops after clear
    // ==========================================================
    // timing
    localparam int SYS_CLK_MHZ   = 50;              // system clock rate
    localparam int SYNC_STAGES   = 2;               // flops in each pin synchroniser
endpackage

// file: chain_if.sv
// interface: carries shift and latch events plus chain state between modules
// assumes: single clk_sys domain, driven by the top module
`timescale 1ns/10ps
interface chain_if;
    logic        shift_rise;   // one-cycle pulse: shift strobe rose
    logic        shift_fall;   // one-cycle pulse: shift strobe fell
    logic        latch_rise;   // one-cycle pulse: latch strobe rose
    logic        wipe;         // level: synchronous clear request
    logic        ser_bit;      // synchronised serial input
    logic [11:0] latch_q;      // storage latch contents
    logic        cascade_q;    // registered cascade output
    modport ctrl (output shift_rise, output shift_fall, output latch_rise,
                  output wipe, output ser_bit, input latch_q, input cascade_q);
    modport chain (input shift_rise, input shift_fall, input latch_rise,
                   input wipe, input ser_bit, output latch_q, output cascade_q);
endinterface

// file: shift_latch_chain.sv
// module: twelve-stage shift chain, storage latch and cascade output flop
// assumes: event pulses are already synchronised to clk_sys
`timescale 1ns/10ps
module shift_latch_chain (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    // events and state
    chain_if.chain    cif
);
    // ==========================================================
    // storage
    logic [11:0] stage_ff;     // shift stages, bit 0 is first
    logic [11:0] latch_ff;     // storage latch
    logic        casc_ff;      // cascade output flop
    wire  [11:0] nxt_stage = {stage_ff[10:0], cif.ser_bit};

    // shift chain: first stage takes serial input, others shift up
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stage_ff <= sink_pkg::CHAIN_RST;
        end else if (cif.wipe) begin
            stage_ff <= sink_pkg::CHAIN_RST;
        end else if (cif.shift_rise) begin
            stage_ff <= nxt_stage;
        end
    end

    // storage latch: parallel copy on latch strobe rise
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            latch_ff <= sink_pkg::LATCH_RST;
        end else if (cif.wipe) begin
            latch_ff <= sink_pkg::LATCH_RST;
        end else if (cif.latch_rise) begin
            latch_ff <= stage_ff;
        end
    end

    // cascade output follows last stage on shift strobe fall
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            casc_ff <= sink_pkg::BIT_RST;
        end else if (cif.wipe) begin
            casc_ff <= sink_pkg::BIT_RST;
        end else if (cif.shift_fall) begin
            casc_ff <= stage_ff[11];
        end
    end

    assign cif.latch_q   = latch_ff;
    assign cif.cascade_q = casc_ff;

    // ==========================================================
    // checks
    property p_shift_in;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (cif.shift_rise && !cif.wipe) |=> (stage_ff[0] == $past(cif.ser_bit));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("first stage missed input");

    property p_shift_up;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (cif.shift_rise && !cif.wipe) |=> (stage_ff[11:1] == $past(stage_ff[10:0]));
    endproperty
    a_shift_up: assert property (p_shift_up) else $error("chain did not shift");

    property p_latch_copy;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (cif.latch_rise && !cif.wipe) |=> (latch_ff == $past(stage_ff));
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("latch copy wrong");

    property p_latch_hold;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!cif.latch_rise && !cif.wipe) |=> $stable(latch_ff);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed unstrobed");

    property p_casc;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (cif.shift_fall && !cif.wipe) |=> (casc_ff == $past(stage_ff[11]));
    endproperty
    a_casc: assert property (p_casc) else $error("cascade not last stage");

    property p_casc_hold;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (cif.shift_rise && !cif.wipe) |=> $stable(casc_ff);
    endproperty
    a_casc_hold: assert property (p_casc_hold) else $error("cascade moved on rise");
endmodule

// file: sink_driver_top.sv
// file: top of the serial-in latched sink driver
// assumes: all device pins are asynchronous to clk_sys and sampled through
// two flops; strobes must stay high and low for more than two clk_sys periods
// assumes: the reset pin may fall at any time; it is released through two flops
// assumes: open-drain channels are pulled up outside, so enable high means on
`timescale 1ns/10ps
module sink_driver_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // serial link pins
    input  wire logic        serial_in,
    input  wire logic        shift_strobe,
    input  wire logic        latch_strobe,
    input  wire logic        register_wipe_n,
    input  wire logic        output_gate_n,
    // cascade output
    output logic             cascade_out,
    // open-drain sink channels: enable high means sinking
    output logic [11:0]      sink_channel_lvl,
    output logic [11:0]      sink_channel_oe
);
    // ==========================================================
    // reset release
    logic [1:0] rst_pipe_ff;   // two-flop reset release
    logic       rst_sync_n;    // released reset for the design

    // reset asserts at once and releases through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= {2{sink_pkg::BIT_RST}};
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'h1};
        end
    end
    assign rst_sync_n = rst_pipe_ff[1];

    // ==========================================================
    // pin synchronisers
    localparam int NPIN = 5;
    wire  [NPIN-1:0] pin_raw = {output_gate_n, register_wipe_n, latch_strobe,
                                shift_strobe, serial_in};
    logic [NPIN-1:0] sync1_ff;   // first flop, read only by second
    logic [NPIN-1:0] sync2_ff;   // second flop, safe to use
    logic [1:0]      edge_ff;    // previous strobe levels for edges

    // one two-flop synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    sync1_ff[gi] <= sink_pkg::BIT_RST;   // pins read low until sampled
                    sync2_ff[gi] <= sink_pkg::BIT_RST;
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    // previous strobe levels for edge detection
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            edge_ff <= {2{sink_pkg::BIT_RST}};   // idle strobes are low: no false edge
        end else begin
            edge_ff <= sync2_ff[2:1];
        end
    end

    // decoded pin levels and edges
    // clear reads active for two cycles after reset, which only empties what is
    // already empty; each edge pulse lasts exactly one clk_sys cycle
    wire ser_lvl    = sync2_ff[0];
    wire shift_lvl  = sync2_ff[1];
    wire latch_lvl  = sync2_ff[2];
    wire wipe_n_lvl = sync2_ff[3];
    wire gate_n_lvl = sync2_ff[4];
    wire shift_rise = shift_lvl & ~edge_ff[0];
    wire shift_fall = ~shift_lvl & edge_ff[0];
    wire latch_rise = latch_lvl & ~edge_ff[1];

    // ==========================================================
    // shift chain and latch
    chain_if cif ();
    assign cif.shift_rise = shift_rise;
    assign cif.shift_fall = shift_fall;
    assign cif.latch_rise = latch_rise;
    assign cif.wipe       = ~wipe_n_lvl;
    assign cif.ser_bit    = ser_lvl;

    shift_latch_chain u_chain (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .cif        (cif)
    );

    // ==========================================================
    // output stage
    wire        pass_ok  = wipe_n_lvl;
    wire        drive_on = pass_ok & ~gate_n_lvl;
    wire [11:0] nxt_sink = drive_on ? cif.latch_q : 12'h000;
    logic [11:0] sink_ff;   // registered output buffer
    logic        casc_out_ff;

    // output buffer and cascade registered for clean pins
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sink_ff     <= sink_pkg::LATCH_RST;
            casc_out_ff <= sink_pkg::BIT_RST;
        end else begin
            sink_ff     <= nxt_sink;
            casc_out_ff <= cif.cascade_q;
        end
    end

    // open drain: a high buffer bit pulls low, a low bit releases
    assign sink_channel_lvl = 12'h000;
    assign sink_channel_oe = sink_ff;
    assign cascade_out     = casc_out_ff;

    // ==========================================================
    // checks
    // gate high empties the buffer one cycle later
    property p_gate_off;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        gate_n_lvl |=> (sink_channel_oe == 12'h000);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("channel on with gate high");

    // gate low and clear high: buffer follows the latch
    property p_gate_on;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!gate_n_lvl && wipe_n_lvl) |=> (sink_channel_oe == $past(cif.latch_q));
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("channel not following latch");

    // clear empties latch and buffer within two cycles
    property p_wipe_off;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !wipe_n_lvl |=> ##1 (sink_channel_oe == 12'h000 && cif.latch_q == 12'h000);
    endproperty
    a_wipe_off: assert property (p_wipe_off) else $error("clear did not empty");

    // latch never reaches the buffer during clear
    property p_pass;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !wipe_n_lvl |=> (sink_channel_oe == 12'h000);
    endproperty
    a_pass: assert property (p_pass) else $error("latch passed during clear");

    // open-drain pins only ever pull low
    property p_pull_low;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        1'h1 |-> (sink_channel_lvl == 12'h000);
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("sink drives high");

    // cascade pin moves only after a strobe fall or a clear
    property p_casc_pin;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        $changed(cascade_out) |-> $past(shift_fall, 2) || $past(cif.wipe, 2);
    endproperty
    a_casc_pin: assert property (p_casc_pin) else $error("cascade moved off fall");

    // a clear holds the cascade pin low one cycle after the buffer
    property p_wipe_casc;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !wipe_n_lvl |=> ##1 (cascade_out == 1'h0);
    endproperty
    a_wipe_casc: assert property (p_wipe_casc) else $error("cascade kept in clear");

    // one pin rise gives one shift event, never two
    property p_rise_once;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        shift_rise |=> !shift_rise;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("shift event repeated");

    // one pin rise gives one latch copy, never two
    property p_latch_once;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        latch_rise |=> !latch_rise;
    endproperty
    a_latch_once: assert property (p_latch_once) else $error("latch event repeated");

    // one pin fall moves the cascade once
    property p_fall_once;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        shift_fall |=> !shift_fall;
    endproperty
    a_fall_once: assert property (p_fall_once) else $error("fall event repeated");

    // steady latch with outputs enabled keeps the buffer steady
    property p_oe_steady;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!gate_n_lvl && wipe_n_lvl) ##1 (!gate_n_lvl && wipe_n_lvl && $stable(cif.latch_q))
        |=> $stable(sink_channel_oe);
    endproperty
    a_oe_steady: assert property (p_oe_steady) else $error("buffer moved");

    // each channel turns on only from its own latch bit
    genvar gc;
    generate
        for (gc = 0; gc < sink_pkg::CHAN_COUNT; gc++) begin : g_chan_chk
            property p_chan_own;
                @(posedge clk_sys) disable iff (!rst_sync_n)
                $rose(sink_channel_oe[gc]) |-> $past(cif.latch_q[gc]);
            endproperty
            a_chan_own: assert property (p_chan_own) else $error("stray channel");
        end
    endgenerate
endmodule

// file: sink_host_model.sv
// file: host model that shifts words into the sink driver and strobes its latch
// assumes: called from bench tasks; pins change on clk_sys falling edges only
`timescale 1ns/10ps
module sink_host_model (
    // clock
    input  wire logic clk_sys,
    // serial link pins
    output logic      serial_in,
    output logic      shift_strobe,
    output logic      latch_strobe
);
    // ==========================================
    // link pins start low; strobes idle low between frames
    initial begin
        serial_in    = 1'h0;
        shift_strobe = 1'h0;
        latch_strobe = 1'h0;
    end
    // wait n falling edges
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // set data, 3 cycles set-up, raise strobe, 4 cycles high
    task automatic put_bit(input logic b);
        serial_in = b;
        gap(3);
        shift_strobe = 1'h1;
        gap(4);
    endtask
    // lower strobe; hold is over so the data line flips; strobe period 8 cycles
    task automatic drop();
        shift_strobe = 1'h0;
        serial_in    = ~serial_in;
        gap(1);
    endtask
    // top bit first, so bit i lands in stage i
    task automatic send_word(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            put_bit(w[i]);
            drop();
        end
    endtask
    // one latch pulse: 4 cycles high, 4 low
    task automatic pulse_latch();
        latch_strobe = 1'h1;
        gap(4);
        latch_strobe = 1'h0;
        gap(4);
    endtask
endmodule

// file: serial_in_latched_sink_driver_bench.sv
// file: self-checking bench for the serial-in latched sink driver
// assumes: host model drives the link pins; gate and clear driven here
`timescale 1ns/10ps
module serial_in_latched_sink_driver_bench;
    // ==========================================
    // signals
    logic        clk_sys;          // 50 MHz system clock
    logic        rst_n;            // reset, active low
    logic        register_wipe_n;  // clear pin, active low
    logic        output_gate_n;    // gate pin, active low
    logic        serial_in;        // from host model
    logic        shift_strobe;     // from host model
    logic        latch_strobe;     // from host model
    logic        cascade_out;      // cascade output
    logic [11:0] sink_channel_lvl; // open-drain value
    logic [11:0] sink_channel_oe;  // high means sinking
    int          failures;         // mismatches
    int          checks_done;      // comparisons
    int          cycles;           // timeout counter
    // clock
    initial clk_sys = 1'h0;
    always #10 clk_sys = ~clk_sys;
    // far side
    sink_host_model host (.clk_sys(clk_sys), .serial_in(serial_in),
        .shift_strobe(shift_strobe), .latch_strobe(latch_strobe));
    // design
    sink_driver_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_in(serial_in),
        .shift_strobe(shift_strobe), .latch_strobe(latch_strobe),
        .register_wipe_n(register_wipe_n), .output_gate_n(output_gate_n),
        .cascade_out(cascade_out), .sink_channel_lvl(sink_channel_lvl),
        .sink_channel_oe(sink_channel_oe));
    // ==========================================
    // compare tasks
    task automatic chk12(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk12("oe after reset", 12'h000, sink_channel_oe);
        chk1("cascade after reset", 1'h0, cascade_out);
    endtask
    // complementary words back to back: every channel on and off
    task automatic t_load();
        logic [11:0] pat [2];
        pat = '{12'ha5c, 12'h5a3};
        foreach (pat[k]) begin
            host.send_word(pat[k]);
            host.pulse_latch();
            chk12("oe word", pat[k], sink_channel_oe);
            chk12("o value", 12'h000, sink_channel_lvl);
        end
    endtask
    // gate high forces off, gate low restores
    task automatic t_gate();
        output_gate_n = 1'h1;
        host.gap(5);
        chk12("oe gated", 12'h000, sink_channel_oe);
        output_gate_n = 1'h0;
        host.gap(5);
        chk12("oe ungated", 12'h5a3, sink_channel_oe);
    endtask
    // cascade moves only after the strobe falls
    task automatic t_cascade();
        host.send_word(12'h800);
        host.gap(4);
        chk1("cascade word", 1'h1, cascade_out);
        host.put_bit(1'h0);
        chk1("cascade strobe high", 1'h1, cascade_out);
        host.drop();
        host.gap(4);
        chk1("cascade after fall", 1'h0, cascade_out);
    endtask
    // clear empties stages, latch and cascade; latch blocked meanwhile
    task automatic t_wipe();
        host.send_word(12'hfff);
        register_wipe_n = 1'h0;
        host.pulse_latch();
        chk12("oe in clear", 12'h000, sink_channel_oe);
        chk1("cascade in clear", 1'h0, cascade_out);
        register_wipe_n = 1'h1;
        host.gap(6);
        host.pulse_latch();
        chk12("oe after clear", 12'h000, sink_channel_oe);
    endtask
    // reset in mid-run empties everything; loading works again after release
    task automatic t_rerun();
        host.send_word(12'hc36);
        host.pulse_latch();
        chk12("oe before reset", 12'hc36, sink_channel_oe);
        chk1("cascade before reset", 1'h1, cascade_out);
        rst_n = 1'h0;
        host.gap(2);
        chk12("oe in reset", 12'h000, sink_channel_oe);
        chk1("cascade in reset", 1'h0, cascade_out);
        rst_n = 1'h1;
        host.gap(5);
        host.pulse_latch();
        chk12("oe stages reset", 12'h000, sink_channel_oe);
        host.send_word(12'h0c9);
        host.pulse_latch();
        chk12("oe reloaded", 12'h0c9, sink_channel_oe);
    endtask
    // ==========================================
    // main sequence
    initial begin
        rst_n           = 1'h0;
        register_wipe_n = 1'h1;
        output_gate_n   = 1'h0;
        failures        = 0;
        checks_done     = 0;
        cycles          = 0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (5) @(negedge clk_sys);
        t_reset();
        t_load();
        t_gate();
        t_cascade();
        t_wipe();
        t_rerun();
        final_report();
    end
endmodule
